// ==== verilog/motor_ctrl_params.svh ====
// Purpose: Shared constants for the serial setup link and its host.
// Assumes: Both ends run on a 125 MHz clock (8 ns period).
// Notes:   Timing figures are given in ns and converted to cycles here.
`ifndef MOTOR_CTRL_PARAMS_SVH
`define MOTOR_CTRL_PARAMS_SVH

`define CLK_PERIOD_NS      8
`define WORD_W             16
// Reset output hold after power-on, least time in ns.
`define RST_HOLD_NS        2000
`define RST_HOLD_CYC       ((`RST_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Delay between converter B start and converters A and C, in ns.
`define DCDC_STAGGER_NS    400
`define DCDC_STAGGER_CYC   ((`DCDC_STAGGER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Host serial clock half period, in ns.
`define SCLK_HALF_NS       40
`define SCLK_HALF_CYC      ((`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Initial setup word fields.
`define INIT_MODE_LSB      0
`define INIT_MODE_MSB      2
`define INIT_BLANK_LSB     4
`define INIT_BLANK_MSB     5
`define INIT_DCDC_ON_BIT   6
`define INIT_GAIN_LSB      7
`define INIT_GAIN_MSB      8
`define INIT_EXT_SEL_BIT   9
// Extended setup word: converter oscillator open and short detection enable.
`define EXT_OSCD_DET_BIT   9
// Step word: current level field of the first axis.
`define STEP_LVL_LSB       0
`define STEP_LVL_MSB       3
`define INIT_RESET_VAL     16'h0000
`define EXT_RESET_VAL      16'h0000

// Host register offsets (byte addresses) and fields.
`define REG_CTRL           4'h0
`define REG_DATA           4'h4
`define REG_STATUS         4'h8
`define REG_INT_STATUS     4'hC
`define REG_INT_MASK       5'h10
`define CTRL_SLEEP_BIT     0
`define CTRL_DC_MODE_BIT   1
`define CTRL_DC_EN_BIT     2
`define CTRL_DC_DIR_BIT    3
`define DATA_PAIR_BIT      16
`define DATA_LEVEL_BIT     17
`define INT_DONE_BIT       0
`define INT_READY_BIT      1
`define STROBE_CYC         8'h08

`endif

// ==== verilog/motor_ctrl_pkg.sv ====
// Purpose: Types shared by the device end and the host end.
// Assumes: Constants live in motor_ctrl_params.svh.
// Notes:   No numbers are defined here.
package motor_ctrl_pkg;
  // Drive configurations selected by the initial setup word.
  typedef enum logic [2:0] {
    MODE_STEP_DUAL,
    MODE_STEP_DCL,
    MODE_STEP_DUAL_DCS,
    MODE_DCL_DUAL_DCS,
    MODE_DUAL_DCL,
    MODE_QUAD_DCS
  } drive_mode_t;

  // Host serial sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOW,
    ST_HIGH,
    ST_STROBE,
    ST_GAP
  } host_state_t;
endpackage

// ==== verilog/motor_link_if.sv ====
// Purpose: Pin bundle between the host and the driver control logic.
// Assumes: The reset line has an external pull-up.
// Notes:   The open-drain line level is resolved here from its enable.
`timescale 1ns/1ps
`default_nettype none
interface motor_link_if;
  logic sleep;                       // High: step data, low: setup.
  logic shift_clock_first_pair;      // Serial clock, first pair.
  logic serial_in_first_pair;        // Serial data, first pair.
  logic latch_pulse_first_pair;      // Strobe, first pair.
  logic shift_clock_second_pair;     // Clock or large DC direction.
  logic serial_in_second_pair;       // Serial data, second pair.
  logic latch_pulse_second_pair;     // Strobe or large DC enable.
  logic external_reset_output_out;   // Open-drain drive level.
  logic external_reset_output_oe;    // High while the pin is pulled low.
  logic external_reset_line;         // Resolved wire level.

  // The pull-up wins whenever the device lets go of the line.
  assign external_reset_line = external_reset_output_oe ?
                               external_reset_output_out : 1'b1;

  modport device (
    input  sleep, shift_clock_first_pair, serial_in_first_pair,
           latch_pulse_first_pair, shift_clock_second_pair,
           serial_in_second_pair, latch_pulse_second_pair,
    output external_reset_output_out, external_reset_output_oe
  );
  modport host (
    output sleep, shift_clock_first_pair, serial_in_first_pair,
           latch_pulse_first_pair, shift_clock_second_pair,
           serial_in_second_pair, latch_pulse_second_pair,
    input  external_reset_line
  );
endinterface
`default_nettype wire

// ==== verilog/motor_setup_device.sv ====
// Purpose: Serial step and setup logic of a dual-axis motor driver.
// Assumes: All link pins are asynchronous and pass two flip-flops.
// Notes:   nrst_in stands for the power-on reset of the driver.
// Operation
// - Step data latched only while sleep high.
// - Sleep low turns writes into setup writes.
// - Host raises sleep after reset release.
// - Sleep high-low-high clears latched motor data.
// - Strobe with data low commits initial setup.
// - Strobe with data high commits extended setup.
// - Initial setup cleared at power-on reset.
// - Extended setup cleared at power-on reset.
// - Initial word, first pair only, sets modes.
// - Host never selects test mode bits.
// - Open chopping oscillator shuts down; short blocks start.
// - Flag when sensed current reaches set level.
// - Optional converter oscillator detection, default off.
// - Converter B starts before A and C.
// - Open-drain reset low during reset, then released.
// - Second pair pins reused per drive mode.
// - Extended writes need sleep low and select.
//
// The Wishbone register port and the register offsets were left to the implementer.
`include "motor_ctrl_params.svh"
`timescale 1ns/1ps
`default_nettype none
module motor_setup_device (
  // Clock and power-on reset.
  input  wire logic                 clk_in,
  input  wire logic                 nrst_in,
  // Link to the host.
  motor_link_if.device              link,
  // Oscillator fault sense pins.
  input  wire logic                 osc_m_open_in,
  input  wire logic                 osc_m_short_in,
  input  wire logic                 osc_d_open_in,
  input  wire logic                 osc_d_short_in,
  // Sensed motor current level of the first axis.
  input  wire logic [3:0]           sense_level_in,
  // Latched words towards the analog stages.
  output logic [`WORD_W-1:0]        step_data_first_out,
  output logic [`WORD_W-1:0]        step_data_second_out,
  output logic [`WORD_W-1:0]        init_setup_out,
  output logic [`WORD_W-1:0]        ext_setup_out,
  // Status and control outputs.
  output logic                      current_reach_comparator_out,
  output logic                      shutdown_out,
  output logic [2:0]                dcdc_enable_out,
  output logic                      large_dc_enable_second_out,
  output logic                      large_dc_direction_second_out
);
  localparam int NSYNC = 11;
  localparam logic [8:0] HOLD_CYC = 9'(`RST_HOLD_CYC);
  localparam logic [6:0] STAG_CYC = 7'(`DCDC_STAGGER_CYC);

  wire  [NSYNC-1:0] raw_in;          // Asynchronous pins.
  logic [NSYNC-1:0] meta;            // First stage, read by stage two only.
  logic [NSYNC-1:0] sync;            // Second stage, safe to use.
  logic [NSYNC-1:0] sync_d;          // Previous value for edge finding.

  assign raw_in = {osc_d_short_in, osc_d_open_in, osc_m_short_in,
                   osc_m_open_in, link.latch_pulse_second_pair,
                   link.serial_in_second_pair, link.shift_clock_second_pair,
                   link.latch_pulse_first_pair, link.serial_in_first_pair,
                   link.shift_clock_first_pair, link.sleep};

  // Two flip-flops per pin, one generate instance each.
  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1) begin : gen_sync
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          meta[g]   <= 1'b0;
          sync[g]   <= 1'b0;
          sync_d[g] <= 1'b0;
        end else begin
          meta[g]   <= raw_in[g];
          sync[g]   <= meta[g];
          sync_d[g] <= sync[g];
        end
      end
    end
  endgenerate

  // Named views of the synchronised pins.
  wire sleep_s   = sync[0];
  wire data1_s   = sync[2];
  wire data2_s   = sync[5];
  wire clk2_s    = sync[4];
  wire stb2_s    = sync[6];
  wire m_open_s  = sync[7];
  wire m_short_s = sync[8];
  wire d_open_s  = sync[9];
  wire d_short_s = sync[10];
  wire sleep_rise = sync[0] & ~sync_d[0];
  wire clk1_rise  = sync[1] & ~sync_d[1];
  wire stb1_rise  = sync[3] & ~sync_d[3];
  wire clk2_rise  = sync[4] & ~sync_d[4];
  wire stb2_rise  = sync[6] & ~sync_d[6];

  logic [8:0]        hold_cnt;       // Reset output hold counter.
  logic              released;       // Reset output no longer driven.
  logic [`WORD_W-1:0] shift1;        // First pair shift register.
  logic [`WORD_W-1:0] shift2;        // Second pair shift register.
  logic [6:0]        stag_cnt;       // Converter stagger counter.

  // Drive mode decoded from the initial setup word.
  wire [2:0] mode_f = init_setup_out[`INIT_MODE_MSB:`INIT_MODE_LSB];
  wire step_dual = (mode_f == 3'(motor_ctrl_pkg::MODE_STEP_DUAL));
  wire ext_sel   = init_setup_out[`INIT_EXT_SEL_BIT];
  wire oscd_det  = ext_setup_out[`EXT_OSCD_DET_BIT];
  wire dcdc_on   = init_setup_out[`INIT_DCDC_ON_BIT];

  // Commit decisions; the strobe data level picks the setup word.
  wire step_ok1  = stb1_rise & sleep_s & released;
  wire init_ok   = stb1_rise & ~sleep_s & ~data1_s;
  wire ext_ok    = stb1_rise & ~sleep_s & data1_s & ext_sel;
  wire step_ok2  = stb2_rise & sleep_s & released & step_dual;

  // Fault detection: open pins shut down at any time, a short during
  // the reset hold keeps the driver from ever starting.
  wire fault_now = m_open_s | (oscd_det & d_open_s);
  wire fault_start = ~released & (m_short_s | (oscd_det & d_short_s));

  // Reset output timer: drives the pin low until the hold has run out.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hold_cnt <= 9'h000;
      released <= 1'b0;
    end else if (!released) begin
      hold_cnt <= hold_cnt + 9'h001;
      released <= (hold_cnt == HOLD_CYC - 9'h001);
    end
  end

  // The open-drain pin pulls low whenever not released.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      link.external_reset_output_out <= 1'b0;
      link.external_reset_output_oe  <= 1'b1;
    end else begin
      link.external_reset_output_out <= 1'b0;
      link.external_reset_output_oe  <= ~released;
    end
  end

  // The first pair shift register takes one bit per rising serial clock, the
  // second one only in dual stepping; the first bit sent ends up in bit 0.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shift1 <= 16'h0000;
      shift2 <= 16'h0000;
    end else begin
      if (clk1_rise) begin
        shift1 <= {data1_s, shift1[`WORD_W-1:1]};
      end
      if (clk2_rise && step_dual) begin
        shift2 <= {data2_s, shift2[`WORD_W-1:1]};
      end
    end
  end

  // Step latches: a sleep rise clears them, since it can only follow a
  // high-to-low fall, and it wins over a strobe in the same cycle.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      step_data_first_out  <= 16'h0000;
      step_data_second_out <= 16'h0000;
    end else if (sleep_rise) begin
      step_data_first_out  <= 16'h0000;
      step_data_second_out <= 16'h0000;
    end else begin
      if (step_ok1) begin
        step_data_first_out <= shift1;
      end
      if (step_ok2) begin
        step_data_second_out <= shift2;
      end
    end
  end

  // Setup words come only from the first pair and only with sleep low;
  // a write for the other word leaves this one alone.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      init_setup_out <= `INIT_RESET_VAL;
      ext_setup_out  <= `EXT_RESET_VAL;
    end else begin
      if (init_ok) begin
        init_setup_out <= shift1;
      end
      if (ext_ok) begin
        ext_setup_out <= shift1;
      end
    end
  end

  // Current reach flag for the first axis, against the latched level.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      current_reach_comparator_out <= 1'b0;
    end else begin
      current_reach_comparator_out <= (sense_level_in >=
        step_data_first_out[`STEP_LVL_MSB:`STEP_LVL_LSB]);
    end
  end

  // Shutdown is sticky until the next power-on reset.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shutdown_out <= 1'b0;
    end else if (fault_now || fault_start) begin
      shutdown_out <= 1'b1;
    end
  end

  // Converter start order: B first, then A and C after the stagger.
  // Bit order of the enable bus is {C, B, A}.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stag_cnt        <= 7'h00;
      dcdc_enable_out <= 3'b000;
    end else if (!dcdc_on || shutdown_out || !released) begin
      stag_cnt        <= 7'h00;
      dcdc_enable_out <= 3'b000;
    end else if (stag_cnt != STAG_CYC) begin
      stag_cnt        <= stag_cnt + 7'h01;
      dcdc_enable_out <= 3'b010;
    end else begin
      dcdc_enable_out <= 3'b111;
    end
  end

  // In DC modes the second pair strobe and clock pins become enable
  // and direction; in dual stepping they are held low here.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      large_dc_enable_second_out    <= 1'b0;
      large_dc_direction_second_out <= 1'b0;
    end else begin
      large_dc_enable_second_out    <= ~step_dual & stb2_s;
      large_dc_direction_second_out <= ~step_dual & clk2_s;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/motor_setup_host.sv ====
// Purpose: Host side serial writer, steered over Wishbone.
// Assumes: Classic Wishbone, 32-bit data, registered one-wait ack.
// Notes:   The serial clock is derived here by a divider.
`include "motor_ctrl_params.svh"
`timescale 1ns/1ps
`default_nettype none
module motor_setup_host (
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // Wishbone slave.
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [4:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  // Interrupt.
  output logic             irq_out,
  // Link to the device.
  motor_link_if.host       link
);
  localparam logic [7:0] HALF = 8'(`SCLK_HALF_CYC);

  motor_ctrl_pkg::host_state_t state;   // Sequencer state.
  logic [3:0]  ctrl;                    // Sleep, DC mode, enable, dir.
  logic [17:0] word;                    // Word, pair, strobe data level.
  logic [4:0]  bit_idx;                 // Bits left to send.
  logic [7:0]  tick;                    // Divider and strobe timer.
  logic [1:0]  int_status;              // Sticky events.
  logic [1:0]  int_mask;                // Enables for the events.
  logic        rst_meta;                // Reset line, first stage.
  logic        rst_line;                // Reset line, synchronised.
  logic        rst_line_d;              // Reset line, one cycle older.
  logic        done_ev;                 // One-cycle end of transfer.

  // Bus decode; sel lane 0 gates control, status clear and mask writes, data writes ignore sel.
  wire req      = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire wr       = req & wb_we_in;
  wire busy     = (state != motor_ctrl_pkg::ST_IDLE);
  wire wr_ctrl  = wr & (wb_adr_in == 5'(`REG_CTRL)) & wb_sel_in[0];
  wire wr_data  = wr & (wb_adr_in == 5'(`REG_DATA)) & ~busy;
  wire wr_istat = wr & (wb_adr_in == 5'(`REG_INT_STATUS)) & wb_sel_in[0];
  wire wr_imask = wr & (wb_adr_in == 5'(`REG_INT_MASK)) & wb_sel_in[0];
  wire tick_end = (tick == HALF - 8'h01);
  wire dc_mode  = ctrl[`CTRL_DC_MODE_BIT];
  // Sleep may only rise once the device has let go of its reset line.
  wire sleep_ok = ctrl[`CTRL_SLEEP_BIT] & rst_line;
  // The release counts once, on the rise of the synced line; a level
  // here would set the bit again every cycle and defeat the clear.
  wire [1:0] ev = {rst_line & ~rst_line_d, done_ev};

  // Read multiplexer; unmapped offsets read as zero.
  wire [31:0] rd_data =
    (wb_adr_in == 5'(`REG_CTRL))       ? {28'h000_0000, ctrl} :
    (wb_adr_in == 5'(`REG_DATA))       ? {14'h0000, word} :
    (wb_adr_in == 5'(`REG_STATUS))     ? {30'h0000_0000, rst_line, busy} :
    (wb_adr_in == 5'(`REG_INT_STATUS)) ? {30'h0000_0000, int_status} :
    (wb_adr_in == 5'(`REG_INT_MASK))   ? {30'h0000_0000, int_mask} :
    32'h0000_0000;

  // Two flip-flops on the open-drain reset line.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta   <= 1'b0;
      rst_line   <= 1'b0;
      rst_line_d <= 1'b0;
    end else begin
      rst_meta   <= link.external_reset_line;
      rst_line   <= rst_meta;
      rst_line_d <= rst_line;
    end
  end

  // Bus answer: ack one cycle after the request, data registered.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= req;
      wb_dat_out <= req ? rd_data : 32'h0000_0000;
    end
  end

  // Control, mask and sticky status; a new event beats a clear.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl       <= 4'h0;
      int_mask   <= 2'b00;
      int_status <= 2'b00;
      irq_out    <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= wb_dat_in[3:0];
      end
      if (wr_imask) begin
        int_mask <= wb_dat_in[1:0];
      end
      int_status <= (int_status & ~(wr_istat ? wb_dat_in[1:0] : 2'b00))
                    | ev;
      irq_out    <= |(int_status & int_mask);
    end
  end

  // Serial sequencer: data changes with the clock low, the device
  // shifts on the rising edge, then the strobe carries the word across.
  // The data line during the strobe selects which setup word is hit.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state   <= motor_ctrl_pkg::ST_IDLE;
      word    <= 18'h0_0000;
      bit_idx <= 5'h00;
      tick    <= 8'h00;
      done_ev <= 1'b0;
    end else begin
      done_ev <= 1'b0;
      unique case (state)
        motor_ctrl_pkg::ST_IDLE: begin
          tick <= 8'h00;
          if (wr_data) begin
            word    <= wb_dat_in[17:0];
            bit_idx <= 5'(`WORD_W);
            state   <= motor_ctrl_pkg::ST_LOW;
          end
        end
        motor_ctrl_pkg::ST_LOW: begin
          tick <= tick_end ? 8'h00 : tick + 8'h01;
          if (tick_end) begin
            state <= motor_ctrl_pkg::ST_HIGH;
          end
        end
        motor_ctrl_pkg::ST_HIGH: begin
          tick <= tick_end ? 8'h00 : tick + 8'h01;
          if (tick_end) begin
            word[15:0] <= {1'b0, word[15:1]};
            bit_idx    <= bit_idx - 5'h01;
            state      <= (bit_idx == 5'h01) ? motor_ctrl_pkg::ST_GAP
                                             : motor_ctrl_pkg::ST_LOW;
          end
        end
        motor_ctrl_pkg::ST_GAP: begin
          tick <= tick_end ? 8'h00 : tick + 8'h01;
          if (tick_end) begin
            state <= motor_ctrl_pkg::ST_STROBE;
          end
        end
        motor_ctrl_pkg::ST_STROBE: begin
          tick <= tick + 8'h01;
          if (tick == `STROBE_CYC - 8'h01) begin
            done_ev <= 1'b1;
            state   <= motor_ctrl_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Pin drive, all registered; second pair pins carry enable and
  // direction in DC mode, and unused pins are held low.
  wire pair2 = word[`DATA_PAIR_BIT];
  wire shift_hi = (state == motor_ctrl_pkg::ST_HIGH);
  wire in_bits = shift_hi | (state == motor_ctrl_pkg::ST_LOW);
  wire in_stb  = (state == motor_ctrl_pkg::ST_STROBE);
  wire gap_stb = in_stb | (state == motor_ctrl_pkg::ST_GAP);
  wire dline   = in_bits ? word[0] : (gap_stb & word[`DATA_LEVEL_BIT]);
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      link.sleep                   <= 1'b0;
      link.shift_clock_first_pair  <= 1'b0;
      link.serial_in_first_pair    <= 1'b0;
      link.latch_pulse_first_pair  <= 1'b0;
      link.shift_clock_second_pair <= 1'b0;
      link.serial_in_second_pair   <= 1'b0;
      link.latch_pulse_second_pair <= 1'b0;
    end else begin
      link.sleep                  <= sleep_ok;
      link.shift_clock_first_pair <= shift_hi & ~pair2;
      link.serial_in_first_pair   <= dline & ~pair2;
      link.latch_pulse_first_pair <= in_stb & ~pair2;
      link.serial_in_second_pair  <= ~dc_mode & dline & pair2;
      link.shift_clock_second_pair <= dc_mode ? ctrl[`CTRL_DC_DIR_BIT]
                                              : (shift_hi & pair2);
      link.latch_pulse_second_pair <= dc_mode ? ctrl[`CTRL_DC_EN_BIT]
                                              : (in_stb & pair2);
    end
  end
endmodule
`default_nettype wire

// ==== verif/motor_link_properties.sv ====
// Purpose: Link timing and reset checks between host and device.
// Assumes: One clock domain; reset asynchronous, active low.
// Notes:   Widths follow the host sequencer settings.
`timescale 1ns/1ps
`default_nettype none
module motor_link_properties (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic nrst_in,
  // Link signals.
  input wire logic sleep,
  input wire logic shift_clock_first_pair,
  input wire logic serial_in_first_pair,
  input wire logic latch_pulse_first_pair,
  input wire logic external_reset_output_oe
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // Serial clock high five cycles, then low.
  sequence clk_half;
    shift_clock_first_pair [*5] ##1 !shift_clock_first_pair;
  endsequence
  // Strobe high eight cycles, then low.
  sequence strobe_len;
    latch_pulse_first_pair [*8] ##1 !latch_pulse_first_pair;
  endsequence
  a_reset_hold: assert property (
    $rose(nrst_in) |-> external_reset_output_oe [*8])
    else $error("reset output let go early");
  a_reset_release: assert property (
    $rose(nrst_in) |-> ##[240:260] !external_reset_output_oe)
    else $error("reset output never let go");
  a_sleep_waits: assert property (
    external_reset_output_oe |-> !sleep)
    else $error("sleep raised during reset");
  a_strobe_width: assert property (
    $rose(latch_pulse_first_pair) |-> strobe_len)
    else $error("strobe width wrong");
  a_clock_half: assert property (
    $rose(shift_clock_first_pair) |-> clk_half)
    else $error("serial clock half period wrong");
  a_clock_quiet: assert property (
    latch_pulse_first_pair |-> !shift_clock_first_pair)
    else $error("clock moved during strobe");
  a_level_held: assert property (
    latch_pulse_first_pair && $past(latch_pulse_first_pair)
      |-> $stable(serial_in_first_pair))
    else $error("data level moved during strobe");
  a_bit_held: assert property (
    shift_clock_first_pair |-> $stable(serial_in_first_pair))
    else $error("data moved while clock high");
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Purpose: Joins host and device and drives the host over Wishbone.
// Assumes: The host answers every cycle with one ack pulse.
// Notes:   A mid-run power-on reset tries the start-up short case.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_in, nrst_in, cyc, we, m_open, ack, irq, reach, sd, l_en;
  logic        d_open, m_short, l_dir;
  logic [4:0]  adr;
  logic [31:0] dat, rd, wdo;
  logic [15:0] s1, s2, ini, ext;
  logic [3:0]  lvl;
  logic [2:0]  dcdc;
  int          n_fail, n_compared;
  motor_link_if link_bus();
  motor_setup_host u_motor_setup_host(.clk_in(clk_in), .nrst_in(nrst_in),
    .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(4'hF), .wb_dat_in(dat), .wb_dat_out(wdo), .wb_ack_out(ack),
    .irq_out(irq), .link(link_bus.host));
  motor_setup_device u_motor_setup_device(.clk_in(clk_in),
    .nrst_in(nrst_in), .link(link_bus.device), .osc_m_open_in(m_open),
    .osc_m_short_in(m_short), .osc_d_open_in(d_open), .osc_d_short_in(1'b0),
    .sense_level_in(lvl), .step_data_first_out(s1),
    .step_data_second_out(s2), .init_setup_out(ini), .ext_setup_out(ext),
    .current_reach_comparator_out(reach), .shutdown_out(sd),
    .dcdc_enable_out(dcdc), .large_dc_enable_second_out(l_en),
    .large_dc_direction_second_out(l_dir));
  motor_link_properties u_props(.clk_in(clk_in), .nrst_in(nrst_in),
    .sleep(link_bus.sleep),
    .shift_clock_first_pair(link_bus.shift_clock_first_pair),
    .serial_in_first_pair(link_bus.serial_in_first_pair),
    .latch_pulse_first_pair(link_bus.latch_pulse_first_pair),
    .external_reset_output_oe(link_bus.external_reset_output_oe));
  // Free-running 125 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // Prints the verdict and stops the run.
  task automatic end_of_test();
    if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Compares one value; unknown never matches.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle, held until ack is sampled high.
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_in);
    cyc <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk_in);
    rd = wdo;
    cyc <= 1'b0;
    if (i == 20) begin
      n_fail++;
      $display("[ERR] %0t bus timeout", $time);
      end_of_test();
    end
  endtask
  // Sends one word, waits for the done interrupt, then clears it.
  task automatic xfer(input logic [17:0] v);
    int i;
    wb(1'b1, 5'h04, {14'h0000, v});
    for (i = 0; i < 400 && irq !== 1'b1; i++) @(posedge clk_in);
    if (i == 400) begin
      n_fail++;
      $display("[ERR] %0t transfer timeout", $time);
      end_of_test();
    end
    wb(1'b1, 5'h0C, 32'h0000_0001);
  endtask
  // Main sequence.
  initial begin
    int i;
    {nrst_in, cyc, we, m_open, d_open, m_short, adr, dat} = '0;
    {n_fail, n_compared} = '0;
    lvl = 4'h4;
    repeat (8) @(posedge clk_in);
    chk(link_bus.external_reset_line, 1'b0);
    chk(ini, 16'h0000);
    chk(ext, 16'h0000);
    nrst_in <= 1'b1;
    for (i = 0; i < 200 && rd[1] !== 1'b1; i++) wb(1'b0, 5'h08, 32'h0);
    if (i == 200) begin
      n_fail++;
      $display("[ERR] %0t reset line stuck", $time);
      end_of_test();
    end
    chk(link_bus.external_reset_line, 1'b1);
    wb(1'b1, 5'h10, 32'h0000_0001);
    xfer(18'h0_0240); // test bits held low
    chk(ini, 16'h0240);
    chk(ext, 16'h0000);
    chk(dcdc, 3'b010);
    repeat (60) @(posedge clk_in);
    chk(dcdc, 3'b111);
    xfer(18'h2_0200);
    chk(ext, 16'h0200);
    chk(s1, 16'h0000);
    wb(1'b1, 5'h00, 32'h0000_0001);
    repeat (10) @(posedge clk_in);
    xfer(18'h2_0005);
    chk(s1, 16'h0005);
    chk(ini, 16'h0240);
    chk(reach, 1'b0);
    lvl <= 4'h5;
    repeat (3) @(posedge clk_in);
    chk(reach, 1'b1);
    xfer(18'h1_00A3);
    chk(s2, 16'h00A3);
    chk(l_en, 1'b0);
    wb(1'b1, 5'h00, 32'h0000_0000);
    wb(1'b1, 5'h00, 32'h0000_0001);
    repeat (10) @(posedge clk_in);
    chk({s1, s2}, 32'h0000_0000);
    // Stepper plus large DC: second pair pins become enable and direction.
    wb(1'b1, 5'h00, 32'h0000_0000);
    xfer(18'h0_0241);
    wb(1'b1, 5'h00, 32'h0000_000F);
    repeat (6) @(posedge clk_in);
    chk({l_en, l_dir}, 2'b11);
    chk(ini, 16'h0241);
    chk(sd, 1'b0);
    m_open <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk(sd, 1'b1);
    // Mid-run power-on reset with only the converter pin left open.
    {m_open, d_open, nrst_in} <= 3'b010;
    repeat (2) @(posedge clk_in);
    chk({ini, ext}, 32'h0000_0000);
    nrst_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk(sd, 1'b0);
    wb(1'b1, 5'h00, 32'h0000_0001);
    m_short <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk(link_bus.sleep, 1'b0);
    chk(sd, 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
